// *** src/tscr_regs.sv ***
// tile configuration and status register bank with an APB slave
// assumes link status, core pause and pc inputs come from logic on SYS_CLK
//
// Summary of operation
// RULE_01 - ram base register loads 0x00010000 on reset
// RULE_02 - ram base bits 31:2 writable and drive ram address; bits 1:0 read zero
// RULE_03 - event target takes high half from vector base, low half from event vector
// RULE_04 - vector base bits 31:16 writable; bits 15:0 read zero
// RULE_05 - control bit 4 enables the power-saving clock divider; resets to 0
// RULE_06 - with bit 5 set, divide only while every active core is paused
// RULE_07 - with bit 5 clear, divide at all times while enabled
// RULE_08 - link status bits 25:24 give the source target kind
// RULE_09 - link status bits 23:16 give channel endpoint id or idle status
// RULE_10 - link status bits 5:4 network id, bit 2 junk packet flag
// RULE_11 - link status bit 1 set when switch routes into link; resets to 0
// RULE_12 - link status bit 0 set when link routes into switch; resets to 0
// RULE_13 - eight 32-bit scratch words read and written by software and debugger
// RULE_14 - core 0 program counter readable, writes ignored
// RULE_15 - node config bit 31 blocks later writes to node config
// RULE_16 - node config bit 0 selects one-byte headers; resets to 0
// RULE_17 - reserved bits read zero and ignore writes
// RULE_18 - lock bit stays set until reset
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps

module tscr_regs #(
  parameter int ADDR_W      = 9,
  parameter int NUM_LINKS   = 4,
  parameter int NUM_SCRATCH = 8
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          SYS_RST,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [ADDR_W-1:0]             PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  input  wire tscr_pkg::tscr_link_t [NUM_LINKS-1:0] LINK_STAT,
  input  wire logic                          CORES_PAUSED,
  input  wire logic [31:0]                   CORE0_PC,
  input  wire logic                          EVT_VALID,
  input  wire logic [15:0]                   EVT_VECTOR,
  output logic      [31:0]                   EVT_TARGET,
  output logic                               EVT_TAKEN,
  output logic      [31:0]                   RAM_BASE,
  output logic                               CLK_DIV_ON,
  output logic                               HEADER_ONE_BYTE,
  input  wire logic                          DBG_WE,
  input  wire logic [2:0]                    DBG_ADDR,
  input  wire logic [31:0]                   DBG_WDATA,
  output logic      [31:0]                   DBG_RDATA
);

  `include "tscr_defs.svh"

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // keep unwritable bits, take writable ones from the bus
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // is the index inside a block of n words starting at base
  function automatic logic in_block(input logic [6:0] i,
                                    input logic [6:0] base,
                                    input int         n);
    logic [7:0] off;
    off = {1'b0, i} - {1'b0, base};
    in_block = (i >= base) && (off < 8'(n));
  endfunction

  function automatic logic [31:0] link_word(input tscr_pkg::tscr_link_t s);
    link_word = {6'h00, s.source_target_kind, s.channel_endpoint, 10'h000,
                 s.network_id, 1'b0, s.junk, s.route_in, s.route_out};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [31:0]          vec_base;
  logic [31:0]          ctrl;
  logic [31:0]          node_cfg;
  logic [31:0]          core0_pc;
  logic [31:0]          scratch [NUM_SCRATCH];
  tscr_pkg::tscr_link_t link_q  [NUM_LINKS];

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire  [6:0] idx      = PADDR[8:2];
  wire        access   = PSEL && PENABLE;
  wire        done     = access && PREADY;
  wire        wr       = done && PWRITE;
  wire        hit_ram  = (idx == `TSCR_IDX_RAM_BASE);
  wire        hit_vec  = (idx == `TSCR_IDX_VEC_BASE);
  wire        hit_ctrl = (idx == `TSCR_IDX_CTRL);
  wire        hit_node = (idx == `TSCR_IDX_NODE_CFG);
  wire        hit_pc   = (idx == `TSCR_IDX_CORE0_PC);
  wire        hit_link = in_block(idx, `TSCR_IDX_LINK0, NUM_LINKS);
  wire        hit_scr  = in_block(idx, `TSCR_IDX_SCRATCH0, NUM_SCRATCH);
  wire        mapped   = hit_ram || hit_vec || hit_ctrl || hit_node ||
                         hit_pc || hit_link || hit_scr;
  wire        locked   = node_cfg[`TSCR_NODE_LOCK];
  wire  [6:0] link_off = idx - `TSCR_IDX_LINK0;
  wire  [6:0] scr_off  = idx - `TSCR_IDX_SCRATCH0;

  wire [31:0] rd_mux =
    hit_ram  ? RAM_BASE :
    hit_vec  ? vec_base :
    hit_ctrl ? ctrl :
    hit_node ? node_cfg :
    hit_pc   ? core0_pc :                                          // RULE_14
    hit_link ? link_word(link_q[link_off[$clog2(NUM_LINKS)-1:0]]) : // RULE_08
    hit_scr  ? scratch[scr_off[$clog2(NUM_SCRATCH)-1:0]] :
    32'h00000000;                                                  // RULE_17

  ////////////////////////////////////////////////////////////////////////////
  // next values

  wire [31:0] next_ram  = merge(RAM_BASE, PWDATA, `TSCR_WMASK_RAM);  // RULE_02
  wire [31:0] next_vec  = merge(vec_base, PWDATA, `TSCR_WMASK_VEC);  // RULE_04
  wire [31:0] next_ctrl = merge(ctrl, PWDATA, `TSCR_WMASK_CTRL);     // RULE_17
  wire [31:0] next_node = merge(node_cfg, PWDATA, `TSCR_WMASK_NODE);

  // dynamic mode lets the divider act only when no core has work
  wire next_div = ctrl[`TSCR_CTRL_DIV_EN] &&                           // RULE_05
                  (!ctrl[`TSCR_CTRL_DYN] || CORES_PAUSED);             // RULE_06 RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, read data and ready leave flops together

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= access && !PREADY;
      PSLVERR <= access && !PREADY && !mapped;
      if (access && !PREADY) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      RAM_BASE <= `TSCR_RST_RAM_BASE;                                  // RULE_01
      vec_base <= `TSCR_RST_VEC_BASE;
      ctrl     <= `TSCR_RST_CTRL;
    end else if (wr) begin
      if (hit_ram) begin
        RAM_BASE <= next_ram;
      end
      if (hit_vec) begin
        vec_base <= next_vec;
      end
      if (hit_ctrl) begin
        ctrl <= next_ctrl;
      end
    end
  end

  // once locked, even the lock itself cannot be cleared
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      node_cfg <= `TSCR_RST_NODE_CFG;
    end else if (wr && hit_node && !locked) begin                      // RULE_15 RULE_18
      node_cfg <= next_node;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scratch words; a same-cycle clash on one word goes to the bus side

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NUM_SCRATCH; i++) begin
        scratch[i] <= 32'h00000000;
      end
      DBG_RDATA <= 32'h00000000;
    end else begin
      if (DBG_WE) begin                                                // RULE_13
        scratch[DBG_ADDR] <= DBG_WDATA;
      end
      if (wr && hit_scr) begin                                         // RULE_13
        scratch[scr_off[$clog2(NUM_SCRATCH)-1:0]] <= PWDATA;
      end
      DBG_RDATA <= scratch[DBG_ADDR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampled status: link state and pc are captured so reads are glitch free

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        link_q[i] <= '0;                                               // RULE_11 RULE_12
      end
      core0_pc <= 32'h00000000;
    end else begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        link_q[i] <= LINK_STAT[i];                                     // RULE_09 RULE_10
      end
      core0_pc <= CORE0_PC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs steered by the registers

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      EVT_TARGET      <= 32'h00000000;
      EVT_TAKEN       <= 1'b0;
      CLK_DIV_ON      <= 1'b0;
      HEADER_ONE_BYTE <= 1'b0;
    end else begin
      EVT_TAKEN       <= EVT_VALID;
      if (EVT_VALID) begin
        EVT_TARGET <= {vec_base[`TSCR_VEC_HI], EVT_VECTOR};            // RULE_03
      end
      CLK_DIV_ON      <= next_div;
      HEADER_ONE_BYTE <= node_cfg[`TSCR_NODE_HDR1];                    // RULE_16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  a_ram_reset_val: assert property ($past(SYS_RST) |-> RAM_BASE == 32'h00010000) // RULE_01
    else $error("ram base not at reset value after reset");

  a_ram_write_hi: assert property (wr && hit_ram |=>                   // RULE_02
    RAM_BASE == {$past(PWDATA[31:2]), 2'h0})
    else $error("ram base write not taken or low bits not zero");

  a_evt_target: assert property (EVT_VALID |=>                         // RULE_03
    EVT_TARGET == {$past(vec_base[31:16]), $past(EVT_VECTOR)} && EVT_TAKEN)
    else $error("event target not formed from vector base and event vector");

  a_vec_low_zero: assert property (wr && hit_vec |=>                   // RULE_04
    vec_base == {$past(PWDATA[31:16]), 16'h0000})
    else $error("vector base write wrong");

  a_div_off: assert property (!ctrl[4] |=> !CLK_DIV_ON)                // RULE_05
    else $error("divider active while disabled");

  a_div_dynamic: assert property (ctrl[4] && ctrl[5] |=>               // RULE_06
    CLK_DIV_ON == $past(CORES_PAUSED))
    else $error("dynamic divider does not follow core pause");

  a_div_static: assert property (ctrl[4] && !ctrl[5] |=> CLK_DIV_ON)   // RULE_07
    else $error("static divider not active");

  a_link_read: assert property (PREADY && !PWRITE && idx == 7'h10 |->  // RULE_08
    PRDATA == link_word($past(link_q[0])))
    else $error("link status read data wrong");

  a_pc_read: assert property (PREADY && !PWRITE && hit_pc |->          // RULE_14
    PRDATA == $past(core0_pc))
    else $error("core 0 pc read data wrong");

  a_lock_blocks: assert property (locked && wr && hit_node |=>         // RULE_15
    node_cfg == $past(node_cfg))
    else $error("node config changed while locked");

  a_lock_sticky: assert property (locked |=> locked)                   // RULE_18
    else $error("lock bit cleared without reset");

  a_hdr_mode: assert property (##1 HEADER_ONE_BYTE == $past(node_cfg[0])) // RULE_16
    else $error("header mode output does not follow node config");

  a_scr_write: assert property (wr && hit_scr |=>                      // RULE_13
    scratch[$past(scr_off[$clog2(NUM_SCRATCH)-1:0])] == $past(PWDATA))
    else $error("scratch word not written from the bus");

  // a debugger write that collides with a bus write to the same word loses
  a_dbg_write: assert property (DBG_WE &&                              // RULE_13
    !(wr && hit_scr && scr_off[2:0] == DBG_ADDR) |=> scratch[$past(DBG_ADDR)] == $past(DBG_WDATA))
    else $error("scratch word not written from the debug port");

  a_dbg_read: assert property (##1 DBG_RDATA == $past(scratch[DBG_ADDR])) // RULE_13
    else $error("debug read data not the addressed scratch word");

  a_scr_read: assert property (PREADY && !PWRITE && hit_scr |->        // RULE_13
    PRDATA == $past(scratch[scr_off[$clog2(NUM_SCRATCH)-1:0]]))
    else $error("scratch read data wrong");

  a_ram_read: assert property (PREADY && !PWRITE && hit_ram |->        // RULE_02
    PRDATA == $past(RAM_BASE))
    else $error("ram base read data wrong");

  a_ram_hold: assert property (!(wr && hit_ram) |=> $stable(RAM_BASE)) // RULE_02
    else $error("ram base changed without a write");

  a_ram_low_zero: assert property (RAM_BASE[1:0] == 2'h0)              // RULE_02
    else $error("ram base reserved bits set");

  a_vec_read: assert property (PREADY && !PWRITE && hit_vec |->        // RULE_04
    PRDATA == $past(vec_base))
    else $error("vector base read data wrong");

  a_vec_hold: assert property (!(wr && hit_vec) |=> $stable(vec_base)) // RULE_04
    else $error("vector base changed without a write");

  a_vec_reserved: assert property (vec_base[15:0] == 16'h0000)         // RULE_04
    else $error("vector base reserved bits set");

  a_evt_hold: assert property (!EVT_VALID |=> $stable(EVT_TARGET) && !EVT_TAKEN) // RULE_03
    else $error("event output moved without an event");

  a_ctrl_write: assert property (wr && hit_ctrl |=>                    // RULE_05
    ctrl[5:4] == $past(PWDATA[5:4]))
    else $error("control write not taken");

  a_ctrl_hold: assert property (!(wr && hit_ctrl) |=> $stable(ctrl))   // RULE_05
    else $error("control changed without a write");

  a_ctrl_reserved: assert property ((ctrl & ~`TSCR_WMASK_CTRL) == 32'h00000000) // RULE_17
    else $error("control reserved bits set");

  a_cfg_reset: assert property ($past(SYS_RST) |->                     // RULE_05 RULE_15 RULE_16
    ctrl == `TSCR_RST_CTRL && node_cfg == `TSCR_RST_NODE_CFG)
    else $error("control or node config not cleared by reset");

  a_out_reset: assert property ($past(SYS_RST) |->                     // RULE_05 RULE_16
    !CLK_DIV_ON && !HEADER_ONE_BYTE)
    else $error("divider or header mode active after reset");

  a_link_reserved: assert property (PREADY && !PWRITE && hit_link |->  // RULE_17
    PRDATA[31:26] == 6'h00 && PRDATA[15:6] == 10'h000 && !PRDATA[3])
    else $error("link status reserved bits not zero");

  // link status is a sampled copy, so reset must clear the route flags as well
  a_link_reset: assert property ($past(SYS_RST) |->                    // RULE_11 RULE_12
    !link_q[0].route_in && !link_q[0].route_out)
    else $error("link route flags not clear after reset");

  a_pc_ro: assert property (wr && hit_pc |=> core0_pc == $past(CORE0_PC)) // RULE_14
    else $error("core 0 pc took a bus write");

  a_node_write: assert property (wr && hit_node && !locked |=>         // RULE_16
    node_cfg == ($past(PWDATA) & `TSCR_WMASK_NODE))
    else $error("node config write not taken");

  a_node_hold: assert property (!(wr && hit_node) |=> $stable(node_cfg)) // RULE_15
    else $error("node config changed without a write");

  a_node_read: assert property (PREADY && !PWRITE && hit_node |->      // RULE_16
    PRDATA == $past(node_cfg))
    else $error("node config read data wrong");

  a_node_reserved: assert property (node_cfg[30:1] == 30'h00000000)    // RULE_17
    else $error("node config reserved bits set");

  a_unmapped_err: assert property (access && !PREADY && !mapped |=>    // RULE_17
    PREADY && PSLVERR && PRDATA == 32'h00000000)
    else $error("unmapped access not refused");

  c_lock_set: cover property (wr && hit_node && !locked ##1 locked);
  c_dyn_div: cover property (ctrl[4] && ctrl[5] && CORES_PAUSED ##1 CLK_DIV_ON);
  c_evt: cover property (EVT_VALID ##1 EVT_TAKEN);
  c_unmapped: cover property (PSLVERR);
  c_link_idle: cover property (PREADY && hit_link && PRDATA[25:24] == 2'h3);

endmodule

// *** src/tscr_defs.svh ***
// constants for the tile configuration register bank: indices, bit positions, masks, resets
// assumes a word-addressed map behind APB; byte address is four times the index
`ifndef TSCR_DEFS_SVH
`define TSCR_DEFS_SVH

// register indices
`define TSCR_IDX_RAM_BASE   7'h00
`define TSCR_IDX_VEC_BASE   7'h01
`define TSCR_IDX_CTRL       7'h02
`define TSCR_IDX_NODE_CFG   7'h04
`define TSCR_IDX_LINK0      7'h10
`define TSCR_IDX_SCRATCH0   7'h20
`define TSCR_IDX_CORE0_PC   7'h40

// reset values
`define TSCR_RST_RAM_BASE   32'h00010000
`define TSCR_RST_VEC_BASE   32'h00000000
`define TSCR_RST_CTRL       32'h00000000
`define TSCR_RST_NODE_CFG   32'h00000000

// writable bits of each register
`define TSCR_WMASK_RAM      32'hfffffffc
`define TSCR_WMASK_VEC      32'hffff0000
`define TSCR_WMASK_CTRL     32'h00000030
`define TSCR_WMASK_NODE     32'h80000001

// field positions
`define TSCR_CTRL_DIV_EN    4
`define TSCR_CTRL_DYN       5
`define TSCR_NODE_LOCK      31
`define TSCR_NODE_HDR1      0
`define TSCR_VEC_HI         31:16

`endif

// *** src/tscr_pkg.sv ***
// types for the tile configuration register bank
// assumes nothing beyond the defs header
package tscr_pkg;

  // current target kind of a processor link
  typedef enum logic [1:0] {
    TSCR_KIND_CHANNEL = 2'h0,
    TSCR_KIND_ERROR   = 2'h1,
    TSCR_KIND_POWER_SLEEP_CONTROL_TARGET   = 2'h2,
    TSCR_KIND_IDLE    = 2'h3
  } tscr_kind_t;

  // live status of one processor link as the switch reports it
  typedef struct packed {
    tscr_kind_t  source_target_kind;
    logic [7:0]  channel_endpoint;
    logic [1:0]  network_id;
    logic        junk;
    logic        route_in;
    logic        route_out;
  } tscr_link_t;

endpackage

// *** tb/tscr_dbg_model.sv ***
// debugger model: posts and fetches scratch words over the debug port of the register bank
// assumes it shares SYS_CLK with the bank and is driven by calls from the bench
`timescale 1ns/100ps

module tscr_dbg_model (
  input  wire logic        clk,
  input  wire logic [31:0] dbg_rdata,
  output logic             dbg_we,
  output logic [2:0]       dbg_addr,
  output logic [31:0]      dbg_wdata
);
  initial begin
    dbg_we    = 1'b0;
    dbg_addr  = 3'h0;
    dbg_wdata = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one strobe is one write; released data shows its inverse so stale data never looks valid
  task automatic put(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    dbg_we    <= 1'b1;
    dbg_addr  <= a;
    dbg_wdata <= d;
    @(posedge clk);
    dbg_we    <= 1'b0;
    dbg_wdata <= ~d;
  endtask

  // read data is registered, so it is taken two edges after the address is set
  task automatic get(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    dbg_addr <= a;
    repeat (2) @(posedge clk);
    d = dbg_rdata;
  endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the tile configuration register bank
// assumes tscr_regs on one clock, an APB master here and the debugger model beside it
`timescale 1ns/100ps

module tb;
  `define TB_CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("mismatch at %0t: got %h want %h", $time, got, exp); end end

  typedef struct packed {
    logic        wr;
    logic [8:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        err;
  } tscr_row_t;

  logic                       SYS_CLK;
  logic                       SYS_RST;
  logic                       psel, penable, pwrite, pready, pslverr;
  logic [8:0]                 paddr;
  logic [31:0]                pwdata, prdata, core0_pc, evt_target, ram_base, dbg_wdata, dbg_rdata;
  tscr_pkg::tscr_link_t [3:0] link_stat;
  logic                       cores_paused, evt_valid, evt_taken, div_on, hdr1, dbg_we;
  logic [15:0]                evt_vector;
  logic [2:0]                 dbg_addr;
  int                         err_total = 0;
  int                         n_tests = 0;

  // write rows expect zero read data; the pc row expects the value driven on the pc input
  tscr_row_t rows [20] = '{
    '{1'b0, 9'h000, 32'h0, 32'h00010000, 1'b0}, '{1'b0, 9'h004, 32'h0, 32'h0, 1'b0},
    '{1'b0, 9'h008, 32'h0, 32'h0, 1'b0}, '{1'b0, 9'h010, 32'h0, 32'h0, 1'b0},
    '{1'b0, 9'h040, 32'h0, 32'h0, 1'b0}, '{1'b1, 9'h000, 32'hffffffff, 32'h0, 1'b0},
    '{1'b0, 9'h000, 32'h0, 32'hfffffffc, 1'b0}, '{1'b1, 9'h004, 32'hffffffff, 32'h0, 1'b0},
    '{1'b0, 9'h004, 32'h0, 32'hffff0000, 1'b0}, '{1'b1, 9'h008, 32'hffffffff, 32'h0, 1'b0},
    '{1'b0, 9'h008, 32'h0, 32'h00000030, 1'b0}, '{1'b1, 9'h080, 32'ha5a5a5a5, 32'h0, 1'b0},
    '{1'b0, 9'h080, 32'h0, 32'ha5a5a5a5, 1'b0}, '{1'b1, 9'h09c, 32'h5a5a5a5a, 32'h0, 1'b0},
    '{1'b0, 9'h09c, 32'h0, 32'h5a5a5a5a, 1'b0}, '{1'b1, 9'h100, 32'h12345678, 32'h0, 1'b0},
    '{1'b0, 9'h100, 32'h0, 32'hc0de0040, 1'b0}, '{1'b0, 9'h0fc, 32'h0, 32'h0, 1'b1},
    '{1'b1, 9'h0a0, 32'h1, 32'h0, 1'b1}, '{1'b0, 9'h003, 32'h0, 32'hfffffffc, 1'b0}};

  tscr_regs i_tscr_regs (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LINK_STAT(link_stat), .CORES_PAUSED(cores_paused), .CORE0_PC(core0_pc), .EVT_VALID(evt_valid),
    .EVT_VECTOR(evt_vector), .EVT_TARGET(evt_target), .EVT_TAKEN(evt_taken), .RAM_BASE(ram_base),
    .CLK_DIV_ON(div_on), .HEADER_ONE_BYTE(hdr1), .DBG_WE(dbg_we), .DBG_ADDR(dbg_addr),
    .DBG_WDATA(dbg_wdata), .DBG_RDATA(dbg_rdata));

  tscr_dbg_model i_tscr_dbg_model (
    .clk(SYS_CLK), .dbg_rdata(dbg_rdata), .dbg_we(dbg_we), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the slave's wait states are not assumed: wait for pready under a bound
  task automatic apb(input logic wr, input logic [8:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge SYS_CLK);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge SYS_CLK);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      final_report();
    end else begin
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge SYS_CLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    logic [31:0]          rd;
    logic                 er;
    logic [31:0]          exp_w;
    tscr_pkg::tscr_link_t lk;
    SYS_RST      = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 9'h000;
    pwdata       = 32'h00000000;
    link_stat    = '0;
    cores_paused = 1'b0;
    core0_pc     = 32'hc0de0040;
    evt_valid    = 1'b0;
    evt_vector   = 16'h0000;
    cyc(16);
    SYS_RST <= 1'b0;
    cyc(1);
    `TB_CHK(ram_base, 32'h00010000)
    `TB_CHK({div_on, hdr1, evt_taken}, 3'h0)
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, er);
      `TB_CHK(rd, rows[i].rdata)
      `TB_CHK(er, rows[i].err)
    end
    `TB_CHK(ram_base, 32'hfffffffc)
    // back-to-back events take the high half from the vector base
    apb(1'b1, 9'h004, 32'habcd1234, rd, er);
    @(posedge SYS_CLK);
    evt_valid  <= 1'b1;
    evt_vector <= 16'h5678;
    @(posedge SYS_CLK);
    evt_vector <= 16'h9abc;
    @(posedge SYS_CLK);
    evt_valid <= 1'b0;
    `TB_CHK({evt_taken, evt_target}, {1'b1, 32'habcd5678})
    @(posedge SYS_CLK);
    `TB_CHK({evt_taken, evt_target}, {1'b1, 32'habcd9abc})
    @(posedge SYS_CLK);
    `TB_CHK(evt_taken, 1'b0)
    // control still holds dynamic mode with the divider on from the table
    cyc(2);
    `TB_CHK(div_on, 1'b0)
    cores_paused <= 1'b1;
    cyc(2);
    `TB_CHK(div_on, 1'b1)
    apb(1'b1, 9'h008, 32'h00000010, rd, er);
    cores_paused <= 1'b0;
    cyc(2);
    `TB_CHK(div_on, 1'b1)
    apb(1'b1, 9'h008, 32'h00000000, rd, er);
    cyc(2);
    `TB_CHK(div_on, 1'b0)
    // every target kind once, with writes to the read-only link words in between
    for (int i = 0; i < 4; i++) begin
      lk = '{tscr_pkg::tscr_kind_t'(i[1:0]), 8'h30 + 8'(i), 2'(3 - i), i[0], i[1], ~i[0]};
      link_stat[i] <= lk;
      exp_w = {6'h00, i[1:0], 8'h30 + 8'(i), 10'h000, 2'(3 - i), 1'b0, i[0], i[1], ~i[0]};
      apb(1'b1, 9'h040 + 9'(4 * i), 32'hffffffff, rd, er);
      apb(1'b0, 9'h040 + 9'(4 * i), 32'h0, rd, er);
      `TB_CHK(rd, exp_w)
    end
    apb(1'b1, 9'h010, 32'h00000001, rd, er);
    cyc(2);
    `TB_CHK(hdr1, 1'b1)
    apb(1'b1, 9'h010, 32'hffffffff, rd, er);
    apb(1'b1, 9'h010, 32'h00000000, rd, er);
    apb(1'b0, 9'h010, 32'h0, rd, er);
    `TB_CHK(rd, 32'h80000001)
    `TB_CHK(hdr1, 1'b1)
    i_tscr_dbg_model.put(3'h3, 32'h0badf00d);
    apb(1'b0, 9'h08c, 32'h0, rd, er);
    `TB_CHK(rd, 32'h0badf00d)
    apb(1'b1, 9'h090, 32'h600dcafe, rd, er);
    i_tscr_dbg_model.get(3'h4, rd);
    `TB_CHK(rd, 32'h600dcafe)
    // a second reset in mid-run must also release the lock
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    cyc(4);
    SYS_RST <= 1'b0;
    cyc(1);
    `TB_CHK(ram_base, 32'h00010000)
    apb(1'b0, 9'h010, 32'h0, rd, er);
    `TB_CHK(rd, 32'h00000000)
    final_report();
  end
endmodule
